// ==== logic/cdc_charger_detect_control.sv ====
/*
 * Control, status and interrupt logic of the USB charger detector.
 * Assumes an external serial engine turns bus transfers into single-cycle
 * register read and write strobes, and that analog front-end results
 * arrive synchronous to mclk.
 */
`default_nettype none

module cdc_charger_detect_control #(
    parameter int CONTACT_TIMEOUT_CYCLES = cdc_pkg::CONTACT_TIMEOUT_CYC,
    parameter int ATTACH_DEBOUNCE_CYCLES = cdc_pkg::ATTACH_DEBOUNCE_CYC,
    parameter int ID_DEB0_CYCLES = cdc_pkg::ID_DEB0_CYC,
    parameter int ID_DEB1_CYCLES = cdc_pkg::ID_DEB1_CYC,
    parameter int ID_DEB2_CYCLES = cdc_pkg::ID_DEB2_CYC,
    parameter int ID_DEB3_CYCLES = cdc_pkg::ID_DEB3_CYC,
    parameter logic [4:0] UART_ID_CODE = 5'h0C,
    parameter logic [7:0] DEVICE_ID = cdc_pkg::DEVICE_ID_DEFAULT
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWData,
    output logic [7:0] regRData,
    input wire cdc_pkg::cdc_sense_s sense,
    output cdc_pkg::cdc_analog_s analog,
    output logic irqPinOut,
    output logic irqPinOe,
    output logic chargeCtlOut,
    output logic chargeCtlOe
);

    logic [7:0] powerSwitch;
    logic [7:0] chargeOptions;
    logic [7:0] detectSequence;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] int1;
    logic [7:0] int2;
    cdc_pkg::cdc_det_e detState;
    logic [24:0] detTimer;
    logic timerExpired;
    logic [3:0] kindCode;
    logic [24:0] attachCount;
    logic vbusStable;
    logic vbusLive;
    logic [24:0] idCount;
    logic [4:0] idStable;
    logic idChange;
    logic autoDone;
    cdc_pkg::cdc_route_e autoRoute;
    logic [15:0] pulseCount;
    logic chargeActive;

    logic vbusGood;
    logic wrPower, wrOptions, wrSequence;
    logic detStart, detFinish, timeoutHit;
    logic attachEvent, overvoltRise;
    logic [7:0] int1Set;
    logic [7:0] int2Set;
    logic pending, faultFlag, pulseLoad, irqActive;
    logic [15:0] pulseLen;
    logic [3:0] next_kind;

    function automatic logic [24:0] idDebounceLimit(input logic [1:0] sel);
        unique case (sel)
            2'h0: idDebounceLimit = 25'(ID_DEB0_CYCLES);
            2'h1: idDebounceLimit = 25'(ID_DEB1_CYCLES);
            2'h2: idDebounceLimit = 25'(ID_DEB2_CYCLES);
            2'h3: idDebounceLimit = 25'(ID_DEB3_CYCLES);
        endcase
    endfunction

    // Codes above KIND_SPECIAL, except KIND_EXTRA_VENDOR, leave the charger disabled.
    function automatic logic chargeFromKind(input logic [3:0] code, input logic compliant);
        if (code == cdc_pkg::KIND_NONE) begin
            chargeFromKind = 1'b0;
        end else if (code == cdc_pkg::KIND_STANDARD) begin
            chargeFromKind = !compliant;
        end else if (code <= cdc_pkg::KIND_SPECIAL || code == cdc_pkg::KIND_EXTRA_VENDOR) begin
            chargeFromKind = 1'b1;
        end else begin
            chargeFromKind = 1'b0;
        end
    endfunction

    assign vbusGood = sense.vbusDetect && !sense.overvolt;
    assign wrPower = regWrite && regAddr == cdc_pkg::ADDR_POWER_SWITCH;
    assign wrOptions = regWrite && regAddr == cdc_pkg::ADDR_CHARGE_OPTIONS;
    assign wrSequence = regWrite && regAddr == cdc_pkg::ADDR_DETECT_SEQUENCE;

    // Control registers; reserved bits of the two mask registers are masked out on write.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            powerSwitch <= cdc_pkg::POWER_SWITCH_RST;
            chargeOptions <= cdc_pkg::CHARGE_OPTIONS_RST;
            mask1 <= 8'h00;
            mask2 <= 8'h00;
        end else begin
            if (wrPower) begin
                powerSwitch <= regWData;
            end
            if (wrOptions) begin
                chargeOptions <= regWData;
            end
            if (regWrite && regAddr == cdc_pkg::ADDR_MASK1) begin
                mask1 <= regWData & cdc_pkg::MASK1_WMASK;
            end
            if (regWrite && regAddr == cdc_pkg::ADDR_MASK2) begin
                mask2 <= regWData & cdc_pkg::MASK2_WMASK;
            end
        end
    end

    // The manual bit is cleared by the finishing sequence unless a write sets it again.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            detectSequence <= cdc_pkg::DETECT_SEQUENCE_RST;
        end else if (wrSequence) begin
            detectSequence <= regWData & cdc_pkg::DETECT_SEQUENCE_WMASK;
        end else if (detFinish) begin
            detectSequence[cdc_pkg::DS_MANUAL] <= 1'b0;
        end
    end

    // Attach debounce: the filtered VBUS level changes only after a stable hold.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            attachCount <= 25'h0000000;
            vbusStable <= 1'b0;
        end else if (vbusGood == vbusStable) begin
            attachCount <= 25'h0000000;
        end else if (attachCount >= 25'(ATTACH_DEBOUNCE_CYCLES - 1)) begin
            attachCount <= 25'h0000000;
            vbusStable <= vbusGood;
        end else begin
            attachCount <= attachCount + 25'h0000001;
        end
    end

    assign attachEvent = (vbusGood != vbusStable) && attachCount >= 25'(ATTACH_DEBOUNCE_CYCLES - 1);

    // ID debounce with a selectable hold time.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idCount <= 25'h0000000;
            idStable <= cdc_pkg::ID_OPEN;
            idChange <= 1'b0;
        end else begin
            idChange <= 1'b0;
            if (sense.idCode == idStable) begin
                idCount <= 25'h0000000;
            end else if (idCount >= idDebounceLimit(chargeOptions[cdc_pkg::CO_DEB +: 2]) - 25'h0000001) begin
                idCount <= 25'h0000000;
                idStable <= sense.idCode;
                idChange <= 1'b1;
            end else begin
                idCount <= idCount + 25'h0000001;
            end
        end
    end

    // Automatic routing from the ID code.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            autoRoute <= cdc_pkg::ROUTE_OPEN;
            autoDone <= 1'b0;
            vbusLive <= 1'b0;
        end else begin
            vbusLive <= vbusStable;
            if (!vbusStable) begin
                autoDone <= 1'b0;
            end else if (!autoDone || (idChange && chargeOptions[cdc_pkg::CO_AUTO])) begin
                autoDone <= 1'b1;
                autoRoute <= (idStable == UART_ID_CODE) ? cdc_pkg::ROUTE_UART : cdc_pkg::ROUTE_XCVR;
            end
        end
    end

    assign detStart = detState == cdc_pkg::DET_IDLE && detectSequence[cdc_pkg::DS_DET_ON]
        && ((vbusStable && !vbusLive) || detectSequence[cdc_pkg::DS_MANUAL]);
    assign timeoutHit = detState == cdc_pkg::DET_CONTACT && detTimer >= 25'(CONTACT_TIMEOUT_CYCLES - 1);
    assign detFinish = detState == cdc_pkg::DET_CLASSIFY && sense.classifyDone;

    always_comb begin
        next_kind = sense.classifyCode;
        if (sense.classifyCode == cdc_pkg::KIND_EXTRA_VENDOR && !chargeOptions[cdc_pkg::CO_EXTRA]) begin
            next_kind = cdc_pkg::KIND_NONE;
        end
    end

    // Detection sequence.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            detState <= cdc_pkg::DET_IDLE;
            detTimer <= 25'h0000000;
            timerExpired <= 1'b0;
            kindCode <= cdc_pkg::KIND_NONE;
        end else begin
            unique case (detState)
                cdc_pkg::DET_IDLE: begin
                    detTimer <= 25'h0000000;
                    if (!vbusStable && vbusLive) begin
                        kindCode <= cdc_pkg::KIND_NONE;
                    end
                    if (detStart) begin
                        timerExpired <= 1'b0;
                        detState <= detectSequence[cdc_pkg::DS_CONTACT]
                            ? cdc_pkg::DET_CONTACT : cdc_pkg::DET_CLASSIFY;
                    end
                end
                cdc_pkg::DET_CONTACT: begin
                    if (!timeoutHit) begin
                        detTimer <= detTimer + 25'h0000001;
                    end
                    if (timeoutHit) begin
                        timerExpired <= 1'b1;
                    end
                    if (sense.contactSeen || (timeoutHit && detectSequence[cdc_pkg::DS_TO_EXIT])) begin
                        detState <= cdc_pkg::DET_CLASSIFY;
                    end
                end
                cdc_pkg::DET_CLASSIFY: begin
                    if (sense.classifyDone) begin
                        kindCode <= next_kind;
                        detState <= cdc_pkg::DET_IDLE;
                    end
                end
                default: begin
                    detState <= cdc_pkg::DET_IDLE;
                end
            endcase
        end
    end

    // Analog controls are registered so that they never glitch.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            analog <= '0;
        end else begin
            if (detState != cdc_pkg::DET_IDLE) begin
                analog.route <= cdc_pkg::ROUTE_OPEN;
            end else if (powerSwitch[cdc_pkg::PS_ROUTE +: 2] == 2'h3) begin
                analog.route <= vbusStable ? autoRoute : cdc_pkg::ROUTE_OPEN;
            end else begin
                analog.route <= cdc_pkg::cdc_route_e'(powerSwitch[cdc_pkg::PS_ROUTE +: 2]);
            end
            analog.pumpOn <= powerSwitch[cdc_pkg::PS_PUMP];
            analog.sleep <= powerSwitch[cdc_pkg::PS_SLEEP] && !vbusGood
                && powerSwitch[cdc_pkg::PS_ROUTE +: 2] == 2'h0 && !powerSwitch[cdc_pkg::PS_PUMP]
                && sense.idCode == cdc_pkg::ID_OPEN;
            analog.idConvOn <= chargeOptions[cdc_pkg::CO_ID_EN] || vbusGood;
            analog.idDebounceSel <= chargeOptions[cdc_pkg::CO_DEB +: 2];
            unique case (detectSequence[cdc_pkg::DS_GATE +: 2])
                cdc_pkg::GATE_OPEN: analog.gateClosed <= 1'b0;
                cdc_pkg::GATE_CLOSED: analog.gateClosed <= sense.vbusDetect;
                cdc_pkg::GATE_LOGIC: analog.gateClosed <= vbusStable && vbusGood && !sense.thermalTrip;
                default: analog.gateClosed <= 1'b0;
            endcase
            analog.dpSourceOn <= detState == cdc_pkg::DET_IDLE && kindCode == cdc_pkg::KIND_DEDICATED;
            analog.classifyRun <= detState == cdc_pkg::DET_CLASSIFY && !sense.classifyDone;
        end
    end

    // Charge-control output; an active charger pulls the pin low.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            chargeActive <= 1'b0;
        end else if (chargeOptions[cdc_pkg::CO_OVERRIDE]) begin
            chargeActive <= chargeOptions[cdc_pkg::CO_FORCE];
        end else begin
            chargeActive <= chargeFromKind(kindCode, chargeOptions[cdc_pkg::CO_COMPLIANT]);
        end
    end

    assign chargeCtlOut = 1'b0;
    assign chargeCtlOe = chargeActive;

    // Interrupt sources.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            overvoltRise <= 1'b0;
        end else begin
            overvoltRise <= sense.overvolt;
        end
    end

    always_comb begin
        int1Set = 8'h00;
        int1Set[cdc_pkg::I1_TIMER] = timeoutHit && !timerExpired;
        int1Set[cdc_pkg::I1_OVERVOLT] = sense.overvolt && !overvoltRise;
        int1Set[cdc_pkg::I1_VBUS] = attachEvent;
        int1Set[cdc_pkg::I1_KIND] = detFinish;
        int2Set = 8'h00;
        int2Set[cdc_pkg::I2_ID] = idChange;
    end

    // Pending bits clear on read; a simultaneous new event keeps its bit set.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            int1 <= 8'h00;
            int2 <= 8'h00;
        end else begin
            int1 <= ((regRead && regAddr == cdc_pkg::ADDR_INT1) ? 8'h00 : int1) | int1Set;
            int2 <= ((regRead && regAddr == cdc_pkg::ADDR_INT2) ? 8'h00 : int2) | int2Set;
        end
    end

    assign pending = |(int1 & mask1) || |(int2 & mask2) || sense.thermalTrip;
    assign faultFlag = sense.overvolt || sense.thermalTrip;
    assign pulseLoad = |(int1Set & mask1) || |(int2Set & mask2);
    assign pulseLen = 16'((powerSwitch[cdc_pkg::PS_WIDTH] ? cdc_pkg::IRQ_LONG_TICKS : cdc_pkg::IRQ_SHORT_TICKS)
        * cdc_pkg::IRQ_TICK_CYC);

    // Edge mode pulse timer; a new event adds one more pulse period.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pulseCount <= 16'h0000;
        end else if (pulseLoad) begin
            pulseCount <= pulseCount + pulseLen;
        end else if (pulseCount != 16'h0000) begin
            pulseCount <= pulseCount - 16'h0001;
        end
    end

    always_comb begin
        if (!powerSwitch[cdc_pkg::PS_IRQ_EN]) begin
            irqActive = faultFlag;
        end else if (powerSwitch[cdc_pkg::PS_EDGE]) begin
            irqActive = pulseCount != 16'h0000;
        end else begin
            irqActive = pending;
        end
    end

    // The pin is open drain: it pulls low when the wanted level is low.
    assign irqPinOut = 1'b0;
    assign irqPinOe = powerSwitch[cdc_pkg::PS_POL] ? !irqActive : irqActive;

    // Register read data, valid the cycle after the read strobe.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRData <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                cdc_pkg::ADDR_DEVICE: regRData <= DEVICE_ID;
                cdc_pkg::ADDR_INT1: regRData <= int1;
                cdc_pkg::ADDR_INT2: regRData <= int2;
                cdc_pkg::ADDR_STAT1: regRData <= {timerExpired, detState != cdc_pkg::DET_IDLE,
                    sense.overvolt, vbusGood, kindCode};
                cdc_pkg::ADDR_STAT2: regRData <= {3'h0, idStable};
                cdc_pkg::ADDR_MASK1: regRData <= mask1;
                cdc_pkg::ADDR_MASK2: regRData <= mask2;
                cdc_pkg::ADDR_POWER_SWITCH: regRData <= powerSwitch;
                cdc_pkg::ADDR_CHARGE_OPTIONS: regRData <= chargeOptions;
                cdc_pkg::ADDR_DETECT_SEQUENCE: regRData <= detectSequence;
                default: regRData <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== logic/cdc_pkg.sv ====
/*
 * Shared constants and types of the charger detect control block:
 * register map, field positions, reset values, timing and codes.
 * Assumes a single 25 MHz clock domain.
 */
`default_nettype none

package cdc_pkg;

    localparam int CLK_HZ = 25_000_000;

    // Register addresses.
    localparam logic [7:0] ADDR_DEVICE = 8'h00;
    localparam logic [7:0] ADDR_INT1 = 8'h01;
    localparam logic [7:0] ADDR_INT2 = 8'h02;
    localparam logic [7:0] ADDR_STAT1 = 8'h03;
    localparam logic [7:0] ADDR_STAT2 = 8'h04;
    localparam logic [7:0] ADDR_MASK1 = 8'h05;
    localparam logic [7:0] ADDR_MASK2 = 8'h06;
    localparam logic [7:0] ADDR_POWER_SWITCH = 8'h07;
    localparam logic [7:0] ADDR_CHARGE_OPTIONS = 8'h08;
    localparam logic [7:0] ADDR_DETECT_SEQUENCE = 8'h09;

    // Reset values and writable bits.
    localparam logic [7:0] POWER_SWITCH_RST = 8'h0D;
    localparam logic [7:0] CHARGE_OPTIONS_RST = 8'h8E;
    localparam logic [7:0] DETECT_SEQUENCE_RST = 8'h8D;
    localparam logic [7:0] DETECT_SEQUENCE_WMASK = 8'hCF;
    localparam logic [7:0] MASK1_WMASK = 8'h87;
    localparam logic [7:0] MASK2_WMASK = 8'h01;
    localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5A;

    // power_switch_control fields.
    localparam int PS_EDGE = 7;
    localparam int PS_WIDTH = 6;
    localparam int PS_POL = 5;
    localparam int PS_IRQ_EN = 4;
    localparam int PS_ROUTE = 2;
    localparam int PS_PUMP = 1;
    localparam int PS_SLEEP = 0;
    // charge_output_options fields.
    localparam int CO_EXTRA = 7;
    localparam int CO_OVERRIDE = 6;
    localparam int CO_FORCE = 5;
    localparam int CO_DEB = 3;
    localparam int CO_COMPLIANT = 2;
    localparam int CO_AUTO = 1;
    localparam int CO_ID_EN = 0;
    // detect_sequence_control fields.
    localparam int DS_GATE = 6;
    localparam int DS_TO_EXIT = 3;
    localparam int DS_CONTACT = 2;
    localparam int DS_MANUAL = 1;
    localparam int DS_DET_ON = 0;
    // Interrupt bit positions.
    localparam int I1_TIMER = 7;
    localparam int I1_OVERVOLT = 2;
    localparam int I1_VBUS = 1;
    localparam int I1_KIND = 0;
    localparam int I2_ID = 0;

    // Times in their own units, then cycles.
    localparam int CONTACT_TIMEOUT_MS = 900;
    localparam int ATTACH_DEBOUNCE_MS = 30;
    localparam int ID_DEB0_US = 500;
    localparam int ID_DEB1_US = 10_000;
    localparam int ID_DEB2_US = 25_000;
    localparam int ID_DEB3_US = 38_600;
    localparam int IRQ_TICK_HZ = 60_000;
    localparam int CONTACT_TIMEOUT_CYC = CLK_HZ / 1000 * CONTACT_TIMEOUT_MS;
    localparam int ATTACH_DEBOUNCE_CYC = CLK_HZ / 1000 * ATTACH_DEBOUNCE_MS;
    localparam int ID_DEB0_CYC = CLK_HZ / 1_000_000 * ID_DEB0_US;
    localparam int ID_DEB1_CYC = CLK_HZ / 1_000_000 * ID_DEB1_US;
    localparam int ID_DEB2_CYC = CLK_HZ / 1_000_000 * ID_DEB2_US;
    localparam int ID_DEB3_CYC = CLK_HZ / 1_000_000 * ID_DEB3_US;
    localparam int IRQ_TICK_CYC = CLK_HZ / IRQ_TICK_HZ;
    localparam int IRQ_SHORT_TICKS = 2;
    localparam int IRQ_LONG_TICKS = 4;

    // Codes.
    localparam logic [3:0] KIND_NONE = 4'h0;
    localparam logic [3:0] KIND_STANDARD = 4'h1;
    localparam logic [3:0] KIND_CHARGING = 4'h2;
    localparam logic [3:0] KIND_DEDICATED = 4'h3;
    localparam logic [3:0] KIND_SPECIAL = 4'h7;
    localparam logic [3:0] KIND_EXTRA_VENDOR = 4'hC;
    localparam logic [4:0] ID_OPEN = 5'h1F;
    localparam logic [1:0] GATE_OPEN = 2'h0;
    localparam logic [1:0] GATE_CLOSED = 2'h1;
    localparam logic [1:0] GATE_LOGIC = 2'h2;

    typedef enum logic [1:0] {ROUTE_OPEN, ROUTE_UART, ROUTE_XCVR, ROUTE_FSM} cdc_route_e;
    typedef enum logic [1:0] {DET_IDLE, DET_CONTACT, DET_CLASSIFY} cdc_det_e;

    typedef struct packed {
        logic vbusDetect;
        logic overvolt;
        logic thermalTrip;
        logic contactSeen;
        logic classifyDone;
        logic [3:0] classifyCode;
        logic [4:0] idCode;
    } cdc_sense_s;

    typedef struct packed {
        cdc_route_e route;
        logic pumpOn;
        logic sleep;
        logic idConvOn;
        logic [1:0] idDebounceSel;
        logic gateClosed;
        logic dpSourceOn;
        logic classifyRun;
    } cdc_analog_s;

endpackage

`default_nettype wire

// ==== testbench/cdc_front_model.sv ====
/* Behavioural analog front end that answers the classifier after lag cycles.
   Assumes no VBUS, an open ID line and data contact as the bench sets it. */
`default_nettype none
module cdc_front_model (
    input wire logic mclk,
    input wire cdc_pkg::cdc_analog_s analog,
    input wire logic thermal,
    input wire logic contact,
    input wire logic [3:0] code,
    input wire logic [3:0] lag,
    output cdc_pkg::cdc_sense_s sense
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic done = 1'b0;
    // The code is shown only with its pulse, so a late sample cannot pass by luck.
    always_ff @(posedge mclk) begin
        cnt <= (analog.classifyRun && !done) ? cnt + 4'h1 : 4'h0;
        done <= analog.classifyRun && !done && cnt == lag;
    end
    assign sense = {2'b00, thermal, contact, done, done ? code : 4'hF, 5'h1F};
endmodule
`default_nettype wire

// ==== testbench/cdc_chk_assertions.sv ====
/* Port checker of the charger detect control block.
   Assumes polarity, edge mode and interrupt enable stay at reset. */
`default_nettype none
module cdc_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWData,
    input wire logic [7:0] regRData,
    input wire cdc_pkg::cdc_sense_s sense,
    input wire cdc_pkg::cdc_analog_s analog,
    input wire logic irqPinOe,
    input wire logic chargeCtlOe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic ovr;
    logic fin;
    assign ovr = regWrite && regAddr == 8'h08 && regWData[6];
    assign fin = sense.classifyDone && analog.classifyRun;
    property p_force_low; ovr && regWData[5] |-> ##2 chargeCtlOe; endproperty
    a_force_low: assert property (p_force_low) else $error("forced output not low");
    property p_force_off; ovr && !regWData[5] |-> ##2 !chargeCtlOe; endproperty
    a_force_off: assert property (p_force_off) else $error("forced output not released");
    property p_run_open; analog.classifyRun |-> analog.route == cdc_pkg::ROUTE_OPEN; endproperty
    a_run_open: assert property (p_run_open) else $error("switches closed in detection");
    property p_manual; regWrite && regAddr == 8'h09 && regWData[1:0] == 2'b11 |-> ##[1:6] analog.classifyRun;
    endproperty
    a_manual: assert property (p_manual) else $error("manual detection not started");
    property p_dcp; fin && sense.classifyCode == cdc_pkg::KIND_DEDICATED |-> ##[1:3] analog.dpSourceOn; endproperty
    a_dcp: assert property (p_dcp) else $error("no D+ source");
    property p_none; fin && sense.classifyCode == cdc_pkg::KIND_NONE |-> ##[2:3] !chargeCtlOe; endproperty
    a_none: assert property (p_none) else $error("charger enabled for nothing");
    property p_unmapped; regRead && regAddr == 8'h0F |=> regRData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_thermal; sense.thermalTrip |-> ##[0:2] irqPinOe; endproperty
    a_thermal: assert property (p_thermal) else $error("thermal flag missing");
    c_done: cover property (fin);
    c_sleep: cover property (analog.sleep);
    c_charge: cover property ($rose(chargeCtlOe));
endmodule
bind cdc_charger_detect_control cdc_chk u_chk (.mclk, .resetn, .regAddr, .regWrite, .regRead, .regWData,
    .regRData, .sense, .analog, .irqPinOe, .chargeCtlOe);
`default_nettype wire

// ==== testbench/testbench.sv ====
/* Self-checking bench of the charger detect control block.
   Assumes the front-end model and the bound checker. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWData = 8'h00;
    logic thermal = 1'b0;
    logic contact = 1'b1;
    logic [3:0] code = 4'h0;
    logic [3:0] lag = 4'h2;
    logic [7:0] regRData, opt, rv;
    logic irqPinOe, chargeCtlOe, irqPinOut, chargeCtlOut;
    logic [3:0] kinds [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'hC};
    logic [7:0] rstv [3] = '{8'h0D, 8'h8E, 8'h8D};
    cdc_pkg::cdc_sense_s sense;
    cdc_pkg::cdc_analog_s analog;
    integer seed = 32'h6c864295;
    int errCount = 0;
    int nCompared = 0;
    always #20 mclk = ~mclk;
    // A short contact timeout keeps the timed-out sequence inside the manual-start window.
    cdc_charger_detect_control #(.CONTACT_TIMEOUT_CYCLES(2), .ATTACH_DEBOUNCE_CYCLES(20)) uut (.mclk, .resetn,
        .regAddr, .regWrite, .regRead, .regWData, .regRData, .sense, .analog, .irqPinOut, .irqPinOe,
        .chargeCtlOut, .chargeCtlOe);
    cdc_front_model model (.mclk, .analog, .thermal, .contact, .code, .lag, .sense);
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWData = d;
        regWrite = 1'b1;
        step(1);
        regWrite = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a);
        regAddr = a;
        regRead = 1'b1;
        step(1);
        regRead = 1'b0;
        rv = regRData;
        step(1);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic printVerdict;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [3:0] expKind(input logic [3:0] c, input logic extra);
        return (c == cdc_pkg::KIND_EXTRA_VENDOR && !extra) ? cdc_pkg::KIND_NONE : c;
    endfunction
    function automatic logic expCe(input logic [3:0] k, input logic comp);
        return !(k == cdc_pkg::KIND_NONE || (k == cdc_pkg::KIND_STANDARD && comp));
    endfunction
    initial begin
        step(10);
        resetn = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(8'h07 + 8'(i));
            chk(rv, rstv[i]);
        end
        wr(8'h09, 8'hB1);
        rd(8'h09);
        chk(rv, 8'h81);
        wr(8'h0F, 8'hFF);
        rd(8'h0F);
        chk(rv, 8'h00);
        wr(8'h09, cdc_pkg::DETECT_SEQUENCE_RST);
        $display("test registers done");
        // Every listed code, with extra-vendor and compliance bits drawn at random.
        for (int i = 0; i < 24; i++) begin
            code = kinds[i % 6];
            lag = 4'h2 + 4'($unsigned($random(seed)) % 8);
            opt = {1'($random(seed)), 4'b0001, 1'($random(seed)), 2'b10};
            wr(8'h08, opt);
            wr(8'h09, 8'h8F);
            rv = 8'h02;
            for (int t = 0; t < 50 && rv[1]; t++) rd(8'h09);
            chk(rv & 8'h02, 8'h00);
            if (rv[1]) break;
            step(2);
            rd(8'h03);
            chk({4'h0, rv[3:0]}, {4'h0, expKind(code, opt[7])});
            chk({7'h0, chargeCtlOe}, {7'h0, expCe(expKind(code, opt[7]), opt[2])});
        end
        $display("test detection done");
        contact = 1'b0;
        wr(8'h09, 8'h8F);
        rv = 8'h02;
        for (int t = 0; t < 50 && rv[1]; t++) rd(8'h09);
        chk(rv & 8'h02, 8'h00);
        rd(8'h03);
        chk(rv & 8'h80, 8'h80);
        rd(8'h01);
        chk(rv & 8'h80, 8'h80);
        contact = 1'b1;
        $display("test contact timeout done");
        wr(8'h08, 8'h6E);
        step(2);
        chk({7'h0, chargeCtlOe}, 8'h01);
        wr(8'h08, 8'h4E);
        step(2);
        chk({7'h0, chargeCtlOe}, 8'h00);
        wr(8'h08, cdc_pkg::CHARGE_OPTIONS_RST);
        chk({5'h0, analog.idDebounceSel, analog.idConvOn}, 8'h02);
        wr(8'h08, 8'h9F);
        chk({5'h0, analog.idDebounceSel, analog.idConvOn}, 8'h07);
        wr(8'h08, cdc_pkg::CHARGE_OPTIONS_RST);
        $display("test override done");
        for (int r = 0; r < 3; r++) begin
            wr(8'h07, {4'h0, 2'(r), 2'b01});
            step(3);
            chk({6'h0, analog.route}, 8'(r));
            chk({7'h0, analog.sleep}, {7'h0, r == 0});
        end
        wr(8'h07, cdc_pkg::POWER_SWITCH_RST);
        $display("test routing done");
        thermal = 1'b1;
        step(2);
        chk({7'h0, irqPinOe}, 8'h01);
        chk({6'h0, irqPinOut, chargeCtlOut}, 8'h00);
        thermal = 1'b0;
        step(2);
        chk({7'h0, irqPinOe}, 8'h00);
        $display("test thermal done");
        printVerdict();
    end
endmodule
`default_nettype wire
